// [src/isp_instruction_sequencer.v]
// Contract
// - enable code enters ISP mode, selects ISR
// - programmer enables before erase, program, verify
// - erase code clears whole array
// - outputs take preloaded values during ISP
// - program code writes ISR to addressed row
// - disable code leaves ISP mode
// - disable code puts ISR between TDI/TDO
// - verify code copies addressed row into ISR
// - sample code selects boundary register, preload
// - TDI and TMS sampled on rising TCK
// - TDO changes on falling TCK, else tristate
`timescale 1ns/1ps
`default_nettype none
`include "isp_seq_consts.vh"

module isp_instruction_sequencer #(
	parameter [`OPCNT_W-1:0] ERASE_CYC   = `ERASE_CYC,    // erase duration in clk cycles
	parameter [`OPCNT_W-1:0] PROGRAM_CYC = `PROGRAM_CYC   // program duration in clk cycles
) (
	input  wire                 clk,
	input  wire                 nrst,
	input  wire                 tck,        // test clock pin
	input  wire                 tms,        // test mode select pin
	input  wire                 tdi,        // test data in pin
	output reg                  tdoOut,     // test data out value
	output reg                  tdoOeN,     // low while tdo is driven
	input  wire [`BSR_W-1:0]    coreOut,    // outputs from user logic
	output wire [`BSR_W-1:0]    pinOut,     // outputs reaching the pins
	output reg                  ispMode,    // device is in ISP mode
	output reg                  opBusy      // erase/program/verify running
);
	// tap controller states
	localparam [3:0] ST_TLR = 4'h0, ST_RTI = 4'h1, ST_SDRS = 4'h2, ST_CDR = 4'h3,
		ST_SDR = 4'h4, ST_E1DR = 4'h5, ST_PDR = 4'h6, ST_E2DR = 4'h7,
		ST_UDR = 4'h8, ST_SIRS = 4'h9, ST_CIR = 4'ha, ST_SIR = 4'hb,
		ST_E1IR = 4'hc, ST_PIR = 4'hd, ST_E2IR = 4'he, ST_UIR = 4'hf;
	// operation kinds
	localparam [1:0] OP_NONE = 2'h0, OP_ERASE = 2'h1, OP_PROG = 2'h2, OP_VER = 2'h3;
	localparam [`OPCNT_W-1:0] VERIFY_CYC = `VERIFY_CYC;  // short enough to stay fixed

	// data register chosen by an instruction; unknown codes fall to bypass
	function [1:0] drSel;
		input [`IR_W-1:0] code;
		begin
			case (code)
				`IR_ENABLE, `IR_ERASE, `IR_PROGRAM,
				`IR_VERIFY, `IR_DISABLE: drSel = `SEL_ISR;
				`IR_SAMPLE:              drSel = `SEL_BSR;
				default:                 drSel = `SEL_BYPASS;
			endcase
		end
	endfunction

	reg  [2:0]          tckSync_q;      // two sync flops plus edge history
	reg  [1:0]          tmsSync_q;      // tms synchroniser
	reg  [1:0]          tdiSync_q;      // tdi synchroniser
	reg  [3:0]          tap_q;          // tap state
	reg  [3:0]          tap_d;          // next tap state
	reg  [`IR_W-1:0]    irShift_q;      // instruction shift stage
	reg  [`IR_W-1:0]    ir_q;           // current instruction
	reg  [`ISR_W-1:0]   isr_q;          // ISP shift register: {row address, row data}
	reg  [`BSR_W-1:0]   bsr_q;          // boundary shift stage
	reg  [`BSR_W-1:0]   preload_q;      // latched boundary outputs
	reg                 bypass_q;       // one-bit bypass stage
	reg  [1:0]          op_q;           // running operation
	reg  [`OPCNT_W-1:0] opCnt_q;        // cycles left in the operation
	reg                 tdo_d;          // serial output candidate

	// edges seen on the second sync flop only
	wire tckRise = tckSync_q[1] & ~tckSync_q[2];
	wire tckFall = ~tckSync_q[1] & tckSync_q[2];
	wire tmsS    = tmsSync_q[1];
	wire tdiS    = tdiSync_q[1];
	wire [1:0] sel = drSel(ir_q);
	wire opDone  = (op_q != OP_NONE) && (opCnt_q == {`OPCNT_W{1'b0}});
	wire [`ROW_W-1:0] rowRd;             // addressed row from the array

	// preloaded values own the pins for the whole ISP session
	assign pinOut = ispMode ? preload_q : coreOut;

	// pin synchronisers
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tckSync_q <= 3'h0;
			tmsSync_q <= 2'h3;
			tdiSync_q <= 2'h3;
		end else begin
			tckSync_q <= {tckSync_q[1:0], tck};
			tmsSync_q <= {tmsSync_q[0], tms};
			tdiSync_q <= {tdiSync_q[0], tdi};
		end
	end

	// tap next-state decode
	always @* begin
		case (tap_q)
			ST_TLR:  tap_d = tmsS ? ST_TLR  : ST_RTI;
			ST_RTI:  tap_d = tmsS ? ST_SDRS : ST_RTI;
			ST_SDRS: tap_d = tmsS ? ST_SIRS : ST_CDR;
			ST_CDR:  tap_d = tmsS ? ST_E1DR : ST_SDR;
			ST_SDR:  tap_d = tmsS ? ST_E1DR : ST_SDR;
			ST_E1DR: tap_d = tmsS ? ST_UDR  : ST_PDR;
			ST_PDR:  tap_d = tmsS ? ST_E2DR : ST_PDR;
			ST_E2DR: tap_d = tmsS ? ST_UDR  : ST_SDR;
			ST_UDR:  tap_d = tmsS ? ST_SDRS : ST_RTI;
			ST_SIRS: tap_d = tmsS ? ST_TLR  : ST_CIR;
			ST_CIR:  tap_d = tmsS ? ST_E1IR : ST_SIR;
			ST_SIR:  tap_d = tmsS ? ST_E1IR : ST_SIR;
			ST_E1IR: tap_d = tmsS ? ST_UIR  : ST_PIR;
			ST_PIR:  tap_d = tmsS ? ST_E2IR : ST_PIR;
			ST_E2IR: tap_d = tmsS ? ST_UIR  : ST_SIR;
			ST_UIR:  tap_d = tmsS ? ST_SDRS : ST_RTI;
			default: tap_d = ST_TLR;
		endcase
	end

	// tap state and instruction path, all on rising tck
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tap_q     <= ST_TLR;
			irShift_q <= `IR_BYPASS;
			ir_q      <= `IR_BYPASS;
			ispMode   <= 1'b0;
		end else if (tckRise) begin
			tap_q <= tap_d;
			case (tap_q)
				ST_TLR:  ir_q      <= `IR_BYPASS;
				ST_CIR:  irShift_q <= {{(`IR_W-2){1'b0}}, 2'h1};   // fixed capture pattern
				ST_SIR:  irShift_q <= {tdiS, irShift_q[`IR_W-1:1]};
				ST_UIR: begin
					ir_q <= irShift_q;
					if (irShift_q == `IR_ENABLE) begin
						ispMode <= 1'b1;
					end else if (irShift_q == `IR_DISABLE) begin
						ispMode <= 1'b0;
					end
				end
				default: ;
			endcase
		end
	end

	// data registers; verify result lands in the ISR at the end of the pulse
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			isr_q     <= {`ISR_W{1'b0}};
			bsr_q     <= {`BSR_W{1'b0}};
			preload_q <= {`BSR_W{1'b0}};
			bypass_q  <= 1'b0;
		end else if (opDone && op_q == OP_VER) begin
			isr_q <= {isr_q[`ISR_W-1:`ROW_W], rowRd};
		end else if (tckRise) begin
			if (tap_q == ST_CDR) begin
				bypass_q <= 1'b0;
				// ISR keeps its contents so verified data can be read back
				if (sel == `SEL_BSR) begin
					bsr_q <= coreOut;
				end
			end else if (tap_q == ST_SDR && !opBusy) begin
				// shifting is frozen while an operation runs
				case (sel)
					`SEL_ISR: isr_q    <= {tdiS, isr_q[`ISR_W-1:1]};
					`SEL_BSR: bsr_q    <= {tdiS, bsr_q[`BSR_W-1:1]};
					default:  bypass_q <= tdiS;
				endcase
			end else if (tap_q == ST_UDR && sel == `SEL_BSR) begin
				preload_q <= bsr_q;
			end
		end
	end

	// operation launch on entry to run-test/idle from update-DR, timed by a down counter
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			op_q    <= OP_NONE;
			opCnt_q <= {`OPCNT_W{1'b0}};
			opBusy  <= 1'b0;
		end else if (opDone) begin
			op_q   <= OP_NONE;
			opBusy <= 1'b0;
		end else if (op_q != OP_NONE) begin
			opCnt_q <= opCnt_q - 1'b1;
		end else if (tckRise && tap_q == ST_UDR && tap_d == ST_RTI && ispMode) begin
			// only the three array codes start work, and only inside ISP mode
			case (ir_q)
				`IR_ERASE: begin
					op_q    <= OP_ERASE;
					opCnt_q <= ERASE_CYC - 1'b1;
					opBusy  <= 1'b1;
				end
				`IR_PROGRAM: begin
					op_q    <= OP_PROG;
					opCnt_q <= PROGRAM_CYC - 1'b1;
					opBusy  <= 1'b1;
				end
				`IR_VERIFY: begin
					op_q    <= OP_VER;
					opCnt_q <= VERIFY_CYC - 1'b1;
					opBusy  <= 1'b1;
				end
				default: ;
			endcase
		end
	end

	// serial output mux
	always @* begin
		case (tap_q)
			ST_SIR:  tdo_d = irShift_q[0];
			ST_SDR: begin
				case (sel)
					`SEL_ISR: tdo_d = isr_q[0];
					`SEL_BSR: tdo_d = bsr_q[0];
					default:  tdo_d = bypass_q;
				endcase
			end
			default: tdo_d = 1'b0;
		endcase
	end

	// tdo moves only on falling tck; released outside the shift states
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tdoOut <= 1'b0;
			tdoOeN <= 1'b1;
		end else if (tckFall) begin
			tdoOut <= tdo_d;
			tdoOeN <= !(tap_q == ST_SIR || tap_q == ST_SDR);
		end
	end

	// array commits at the end of the pulse, as real cells would
	nv_row_array uArray (
		.clk      (clk),
		.nrst     (nrst),
		.eraseAll (opDone && op_q == OP_ERASE),
		.writeEn  (opDone && op_q == OP_PROG),
		.addr     (isr_q[`ISR_W-1:`ROW_W]),
		.wrData   (isr_q[`ROW_W-1:0]),
		.rdData   (rowRd)
	);
endmodule
`default_nettype wire

// [src/isp_seq_consts.vh]
`ifndef ISP_SEQ_CONSTS_VH
`define ISP_SEQ_CONSTS_VH

// instruction register
`define IR_W            5
`define IR_SAMPLE       5'h02
`define IR_ENABLE       5'h09
`define IR_ERASE        5'h0a
`define IR_PROGRAM      5'h0b
`define IR_VERIFY       5'h0c
`define IR_DISABLE      5'h10
`define IR_BYPASS       5'h1f

// data register geometry
`define ROW_W           16
`define ADDR_W          3
`define ROWS            8
`define ISR_W           19
`define BSR_W           8

// data register select codes
`define SEL_BYPASS      2'h0
`define SEL_ISR         2'h1
`define SEL_BSR         2'h2

// operation times and clock rate
`define CLK_MHZ         250
`define T_ERASE_MS      100
`define T_PROGRAM_MS    10
`define T_VERIFY_US     10
`define ERASE_CYC       (`T_ERASE_MS * 1000 * `CLK_MHZ)
`define PROGRAM_CYC     (`T_PROGRAM_MS * 1000 * `CLK_MHZ)
`define VERIFY_CYC      (`T_VERIFY_US * `CLK_MHZ)
`define OPCNT_W         25

`endif

// [src/nv_row_array.v]
`timescale 1ns/1ps
`default_nettype none
`include "isp_seq_consts.vh"

module nv_row_array (
	input  wire                 clk,
	input  wire                 nrst,
	input  wire                 eraseAll,   // clear every row
	input  wire                 writeEn,    // write one row
	input  wire [`ADDR_W-1:0]   addr,       // row index
	input  wire [`ROW_W-1:0]    wrData,     // row contents to write
	output reg  [`ROW_W-1:0]    rdData      // registered row contents
);
	wire [`ROW_W-1:0] rowQ [0:`ROWS-1];   // row storage outputs

	// one flip-flop row per address; erased state is all ones
	genvar i;
	generate
		for (i = 0; i < `ROWS; i = i + 1) begin : gRow
			reg [`ROW_W-1:0] cell_q;
			always @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					cell_q <= {`ROW_W{1'b1}};
				end else if (eraseAll) begin
					cell_q <= {`ROW_W{1'b1}};
				end else if (writeEn && addr == i) begin
					cell_q <= wrData;
				end
			end
			assign rowQ[i] = cell_q;
		end
	endgenerate

	// read port registered so the data output comes from a flop
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdData <= {`ROW_W{1'b0}};
		end else begin
			rdData <= rowQ[addr];
		end
	end
endmodule
`default_nettype wire

// [tb/isp_seq_checker_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "isp_seq_consts.vh"

module isp_seq_checker #(
	parameter [`OPCNT_W-1:0] ERASE_CYC   = `ERASE_CYC,   // handed on from the block
	parameter [`OPCNT_W-1:0] PROGRAM_CYC = `PROGRAM_CYC  // handed on from the block
) (
	input wire logic              clk,
	input wire logic              nrst,
	input wire logic              tck,
	input wire logic              tms,
	input wire logic              tdi,
	input wire logic              tdoOut,
	input wire logic              tdoOeN,
	input wire logic [`BSR_W-1:0] coreOut,
	input wire logic [`BSR_W-1:0] pinOut,
	input wire logic              ispMode,
	input wire logic              opBusy
);
	// one domain, quiet while reset is held
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// longest operation the block may run; a stuck busy flag overruns it
	localparam int LONG_OP  = (ERASE_CYC > PROGRAM_CYC) ? ERASE_CYC : PROGRAM_CYC;
	localparam int BUSY_MAX = (LONG_OP > `VERIFY_CYC) ? LONG_OP : `VERIFY_CYC;
	logic [`OPCNT_W:0] busyCnt_q;   // cycles busy has stood high, one spare bit

	// busy length counter; a delay range this long would choke the tools
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busyCnt_q <= '0;
		end else if (opBusy) begin
			busyCnt_q <= busyCnt_q + 1'b1;
		end else begin
			busyCnt_q <= '0;
		end
	end

	a_pins_follow_core: assert property (!ispMode |-> pinOut == coreOut)
		else $error("pins differ from core outside isp mode");
	a_busy_needs_isp: assert property ($rose(opBusy) |-> ispMode)
		else $error("operation started outside isp mode");
	a_busy_on_rise: assert property ($rose(opBusy) |-> tck)
		else $error("operation started away from a test clock rise");
	a_busy_min_len: assert property ($rose(opBusy) |-> opBusy[*8])
		else $error("operation ended too early");
	a_busy_bounded: assert property (busyCnt_q <= BUSY_MAX)
		else $error("operation never ended");
	a_tdo_on_fall: assert property ($changed(tdoOut) |-> !tck)
		else $error("tdo moved while test clock high");
	a_oe_on_fall: assert property ($changed(tdoOeN) |-> !tck)
		else $error("tdo enable moved while test clock high");
	a_pins_frozen: assert property (opBusy && $past(opBusy) |-> $stable(pinOut))
		else $error("pins moved during an operation");
endmodule

bind isp_instruction_sequencer isp_seq_checker #(.ERASE_CYC(ERASE_CYC), .PROGRAM_CYC(PROGRAM_CYC)) i_chk (
	.clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOeN(tdoOeN),
	.coreOut(coreOut), .pinOut(pinOut), .ispMode(ispMode), .opBusy(opBusy));
`default_nettype wire

// [tb/jtag_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module jtag_host_model (
	output var logic  tck,
	output var logic  tms,
	output var logic  tdi,
	input  wire logic tdoOut,
	input  wire logic tdoOeN
);
	wire logic tdoWire; // board level of tdo
	// a released tdo floats up to the pull-up
	assign tdoWire = tdoOeN ? 1'b1 : tdoOut;
	// test clock stands low between frames
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// one 64 ns period, odd offsets keep it off the system clock phase
	task automatic tick(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#16.3;
		o = tdoWire;
		tck = 1'b1;
		#32;
		tck = 1'b0;
		#8;
		tdi = 1'b1; // hold time over, back to pull-up level
		#7.7;
	endtask
	// five highs reach test-logic-reset, then park in idle
	task automatic reset;
		logic o;
		repeat (5) tick(1'b1, 1'b1, o);
		tick(1'b0, 1'b1, o);
	endtask
	// full scan from idle back to idle, lsb first
	task automatic scan(input logic ir, input int n, input logic [18:0] d, output logic [18:0] q);
		logic o;
		q = '0;
		tick(1'b1, 1'b1, o);
		if (ir) tick(1'b1, 1'b1, o);
		tick(1'b0, 1'b1, o); // capture
		tick(1'b0, 1'b1, o); // into shift
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, d[i], o);
			q[i] = o;
		end
		tick(1'b1, 1'b1, o); // update
		tick(1'b0, 1'b1, o); // idle, operations launch here
	endtask
endmodule
`default_nettype wire

// [tb/tb_isp_instruction_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "isp_seq_consts.vh"

module tb_isp_instruction_sequencer;
	logic              clk, nrst, tck, tms, tdi, tdoOut, tdoOeN, ispMode, opBusy;
	logic              sawBusy;          // an operation ran since last clear
	logic [`BSR_W-1:0] coreOut, pinOut;
	logic [18:0]       q;                // last shifted-out value
	int                err_count, cmp_count;

	// short operation times keep the run brief
	isp_instruction_sequencer #(.ERASE_CYC(25'd20), .PROGRAM_CYC(25'd10)) i_dut (
		.clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOeN(tdoOeN),
		.coreOut(coreOut), .pinOut(pinOut), .ispMode(ispMode), .opBusy(opBusy));
	jtag_host_model i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdoOut(tdoOut), .tdoOeN(tdoOeN));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// remember any busy pulse, short ones included
	always @(posedge clk) if (opBusy === 1'b1) sawBusy <= 1'b1;

	task automatic check(input logic [18:0] seen, input logic [18:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// bounded wait, a hang ends the run
	task automatic wait_idle;
		int i;
		for (i = 0; i < 4000 && opBusy !== 1'b0; i++) @(negedge clk);
		if (i == 4000) begin
			err_count++;
			stop_test;
		end
	endtask
	// instruction, data scan, wait, then whether an operation ran
	task automatic op(input logic [4:0] code, input int n, input logic [18:0] d, input logic busy);
		@(negedge clk) sawBusy = 1'b0;
		i_host.scan(1'b1, 5, {14'h0, code}, q);
		i_host.scan(1'b0, n, d, q);
		wait_idle;
		check(19'(sawBusy), 19'(busy));
	endtask
	// verify a row, shift it out, compare
	task automatic read_row(input logic [2:0] a, input logic [15:0] exp);
		op(`IR_VERIFY, 19, {a, 16'h0}, 1'b1);
		i_host.scan(1'b0, 19, {a, 16'h0}, q);
		check(19'(q[15:0]), 19'(exp));
		wait_idle;
	endtask

	task automatic t_reset;
		check(19'({ispMode, opBusy, tdoOeN}), 19'h1);
		check(19'(pinOut), 19'h3c);
		$display("test reset done");
	endtask
	task automatic t_refuse;
		op(`IR_PROGRAM, 19, {3'd1, 16'h0}, 1'b0);
		check(19'(ispMode), 19'h0);
		$display("test refuse done");
	endtask
	task automatic t_enter;
		i_host.scan(1'b1, 5, 19'(`IR_ENABLE), q);
		check(19'(q[4:0]), 19'h01);
		check(19'(ispMode), 19'h1);
		op(`IR_SAMPLE, 8, 19'ha5, 1'b0);
		check(19'(pinOut), 19'ha5);
		op(5'h07, 19, 19'h0, 1'b0);
		$display("test enter done");
	endtask
	task automatic t_erase_program;
		op(`IR_PROGRAM, 19, {3'd3, 16'h1234}, 1'b1);
		read_row(3'd3, 16'h1234);
		op(`IR_ERASE, 19, 19'h0, 1'b1);
		read_row(3'd3, 16'hffff);
		op(`IR_PROGRAM, 19, {3'd3, 16'h1234}, 1'b1);
		check(19'(pinOut), 19'ha5);
		read_row(3'd2, 16'hffff);
		read_row(3'd3, 16'h1234);
		$display("test erase program done");
	endtask
	task automatic t_exit;
		op(`IR_DISABLE, 19, 19'h0, 1'b0);
		check(q, {3'd3, 16'h1234});
		check(19'({ispMode, pinOut}), 19'h3c);
		check(19'(tdoOeN), 19'h1);
		$display("test exit done");
	endtask

	initial begin
		nrst = 1'b0;
		coreOut = 8'h3c;
		sawBusy = 1'b0;
		err_count = 0;
		cmp_count = 0;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		t_reset;
		i_host.reset;
		t_refuse;
		t_enter;
		t_erase_program;
		t_exit;
		stop_test;
	end
endmodule
`default_nettype wire
